// File: hw/rsc_defines.vh
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// register byte offsets
`define RSC_ADDR_CTRL      12'h000
`define RSC_ADDR_BAUD      12'h004
`define RSC_ADDR_PATTERN   12'h008
`define RSC_ADDR_TXDATA    12'h00c
`define RSC_ADDR_RXDATA    12'h010
`define RSC_ADDR_STATUS    12'h014
`define RSC_ADDR_SYSCLK    12'h018

// control word fields
`define RSC_CTRL_RXEN      0
`define RSC_CTRL_TXEN      1
`define RSC_CTRL_RXEXT     2
`define RSC_CTRL_TXEXT     3
`define RSC_CTRL_CODEN     4
`define RSC_CTRL_CODE_LO   5
`define RSC_CTRL_CODE_HI   7

// baud / start / irq word fields
`define RSC_BAUD_FINE_LO   0
`define RSC_BAUD_FINE_HI   3
`define RSC_BAUD_CRS_LO    4
`define RSC_BAUD_CRS_HI    5
`define RSC_BAUD_START_LO  6
`define RSC_BAUD_START_HI  7
`define RSC_BAUD_IRQ_LO    8
`define RSC_BAUD_IRQ_HI    10

// status word fields
`define RSC_ST_TXEMPTY     0
`define RSC_ST_TXFULL      1
`define RSC_ST_RXEMPTY     2
`define RSC_ST_RXFULL      3
`define RSC_ST_OVERRUN     4

// line codes
`define RSC_CODE_NRZL      3'h0
`define RSC_CODE_NRZM      3'h1
`define RSC_CODE_NRZS      3'h2
`define RSC_CODE_MANL      3'h3
`define RSC_CODE_MANM      3'h4
`define RSC_CODE_MILLER    3'h7

// start detection modes
`define RSC_START_OFF      2'h0
`define RSC_START_VIOL     2'h1
`define RSC_START_PIN      2'h2
`define RSC_START_PATTERN  2'h3

// receive interrupt sources
`define RSC_IRQ_START      3'h1
`define RSC_IRQ_BYTE       3'h2
`define RSC_IRQ_FULL       3'h4

// baud generator: samples per symbol and coarse shifts (x1, x4, x16, x64)
`define RSC_OVERSAMPLE_M1  4'hf
`define RSC_SAMPLE_PHASE   4'h7
`define RSC_CRS_SH0        2'h0
`define RSC_CRS_SH1        2'h2
`define RSC_CRS_SH2        2'h2
`define RSC_CRS_SH3        2'h3

`endif

// File: hw/rsc_radio_serial.v
// Summary of operation
// - symbol rate = clock / (16*fine*coarse)
// - fine = value+1; coarse 00 x1, 01 x4
// - Manchester/Miller use two symbols per bit
// - code 100 ManMark, 010 NRZ Space, 111 Miller
// - code 000 NRZL, 001 NRZM, 011 ManLevel
// - coder disabled sends raw FIFO bytes
// - coder enable latched at byte load only
// - NRZ Space toggles line per zero bit
// - 4-byte tx FIFO, irq when emptied
// - rx irq source 001 is start detected
// - rx irq source 100 is FIFO full; 4 bytes
// - byte into full rx FIFO dropped, overrun
// - start detection flushes receive FIFO
// - start mode 01 detects code violation
// - start mode 11 pattern, 10 pin
// - clock select 0 uses internal baud timing
// - separate receiver and transmitter enables
// - four pins: rx, bitclock, pattern, tx
// - external system clock divided by two
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.vh"

module rsc_radio_serial #(
  parameter DEPTH = 4
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // radio pins
  input  wire        radio_rx_data_pin,
  input  wire        radio_bitclock_pin,
  input  wire        radio_pattern_pin,
  output reg         radio_tx_data_pin,
  // external system clock input
  input  wire        ext_clk_in,
  // interrupt requests to the system handler
  output reg         tx_irq,
  output reg         rx_irq
);
  localparam AW = 2;

  // configuration
  reg        receiver_enable;
  reg        transmitter_enable;
  reg        rx_external_bitclock_select;
  reg        tx_external_bitclock_select;
  reg        coder_enable;
  reg  [2:0] line_code_select;
  reg  [3:0] baud_fine_factor;
  reg  [1:0] baud_coarse_factor;
  reg  [1:0] start_detect_mode;
  reg  [2:0] rx_interrupt_source;
  reg  [7:0] start_pattern_value;
  reg        external_clock_select;
  reg        rx_overrun_flag;

  // fifos
  reg  [7:0]  tx_mem [0:DEPTH-1];
  reg  [7:0]  rx_mem [0:DEPTH-1];
  reg  [AW-1:0] tx_rd;
  reg  [AW-1:0] tx_wr;
  reg  [AW:0]   tx_cnt;
  reg  [AW-1:0] rx_rd;
  reg  [AW-1:0] rx_wr;
  reg  [AW:0]   rx_cnt;
  wire tx_empty = (tx_cnt == 0);
  wire tx_full  = (tx_cnt == DEPTH);
  wire rx_empty = (rx_cnt == 0);
  wire rx_full  = (rx_cnt == DEPTH);

  // apb decode
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire a_ctrl  = (paddr == `RSC_ADDR_CTRL);
  wire a_baud  = (paddr == `RSC_ADDR_BAUD);
  wire a_pat   = (paddr == `RSC_ADDR_PATTERN);
  wire a_tx    = (paddr == `RSC_ADDR_TXDATA);
  wire a_rx    = (paddr == `RSC_ADDR_RXDATA);
  wire a_st    = (paddr == `RSC_ADDR_STATUS);
  wire a_sys   = (paddr == `RSC_ADDR_SYSCLK);
  wire mapped  = a_ctrl | a_baud | a_pat | a_tx | a_rx | a_st | a_sys;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  wire wr_en   = access & pwrite & mapped;
  wire tx_push = wr_en & a_tx & ~tx_full;
  wire rx_pop  = access & ~pwrite & a_rx & ~rx_empty;

  // system clock: external input halved into a core enable
  reg ext_prev;
  reg ext_half;
  wire ext_rise = ext_clk_in & ~ext_prev;
  wire core_en  = external_clock_select ? (ext_rise & ext_half) : 1'b1;

  // baud generator
  // three bits: the x64 shift of 6 would wrap in two
  reg  [2:0]  crs_sh;
  always @* begin
    case (baud_coarse_factor)
      2'h0:    crs_sh = {1'b0, `RSC_CRS_SH0};
      2'h1:    crs_sh = {1'b0, `RSC_CRS_SH1};
      2'h2:    crs_sh = {1'b0, `RSC_CRS_SH2} + {1'b0, `RSC_CRS_SH2};
      default: crs_sh = {1'b0, `RSC_CRS_SH3} + {1'b0, `RSC_CRS_SH3};
    endcase
  end
  wire [10:0] div_m1 = ({6'h00, 1'b0, baud_fine_factor} + 11'h001 << crs_sh) - 11'h001;
  reg  [10:0] pre_cnt;
  reg  [3:0]  os_cnt;
  wire os_tick  = core_en & (pre_cnt == div_m1);
  wire sym_tick = os_tick & (os_cnt == `RSC_OVERSAMPLE_M1);

  // external bit clock edge
  reg  bclk_prev;
  wire bclk_rise = radio_bitclock_pin & ~bclk_prev;

  // transmitter
  reg        tx_busy;
  reg  [7:0] tx_sh;
  reg  [2:0] tx_bit;
  reg        tx_half;
  reg        tx_code_on;
  reg  [2:0] tx_code;
  reg        tx_prevb;
  wire tx_tick = transmitter_enable &
                 (tx_external_bitclock_select ? bclk_rise : sym_tick);
  wire tx_load_idle = tx_tick & ~tx_busy & ~tx_empty;
  wire tx_two  = tx_code_on & (tx_code == `RSC_CODE_MANL | tx_code == `RSC_CODE_MANM |
                 tx_code == `RSC_CODE_MILLER);
  wire tx_bit_end = tx_tick & tx_busy & (tx_half | ~tx_two);
  wire tx_load_next = tx_bit_end & (tx_bit == 3'h7) & ~tx_empty;
  wire tx_pop = tx_load_idle | tx_load_next;
  wire [7:0] tx_head = tx_mem[tx_rd];

  // next line level for current half symbol
  reg        next_line;
  reg  [2:0] cur_code;
  reg        cur_on;
  reg        cur_b;
  reg        cur_half;
  always @* begin
    cur_code = tx_load_idle ? line_code_select : tx_code;
    cur_on   = tx_load_idle ? coder_enable : tx_code_on;
    cur_b    = tx_load_idle ? tx_head[7] : tx_sh[7];
    cur_half = tx_load_idle ? 1'b0 : tx_half;
    next_line = radio_tx_data_pin;
    if (!cur_on) begin
      next_line = cur_b;
    end else begin
      case (cur_code)
        `RSC_CODE_NRZL:   next_line = cur_b;
        `RSC_CODE_NRZM:   next_line = cur_b ? ~radio_tx_data_pin : radio_tx_data_pin;
        `RSC_CODE_NRZS:   next_line = cur_b ? radio_tx_data_pin : ~radio_tx_data_pin;
        `RSC_CODE_MANL:   next_line = cur_half ? ~cur_b : cur_b;
        `RSC_CODE_MANM:   next_line = (cur_half & ~cur_b) ? radio_tx_data_pin :
                                      ~radio_tx_data_pin;
        `RSC_CODE_MILLER: next_line = cur_half ? (cur_b ^ radio_tx_data_pin) :
                                      ((~cur_b & ~tx_prevb) ^ radio_tx_data_pin);
        default:          next_line = cur_b;
      endcase
    end
  end

  // receiver symbol timing
  reg  [3:0] rx_phase;
  reg        rx_lvl;
  wire rx_int_sym = os_tick & (rx_phase == `RSC_SAMPLE_PHASE);
  wire sym_valid  = receiver_enable &
                    (rx_external_bitclock_select ? bclk_rise : rx_int_sym);
  wire sym = radio_rx_data_pin;

  // receiver decoder
  reg        s1;
  reg        s2;
  reg        rx_havea;
  reg        rx_prevbit;
  reg  [7:0] rx_sh;
  reg  [2:0] rx_bits;
  reg        pat_prev;
  reg        bit_valid;
  reg        bit_val;
  reg        viol;
  wire rx_two = coder_enable & (line_code_select == `RSC_CODE_MANL |
                line_code_select == `RSC_CODE_MANM | line_code_select == `RSC_CODE_MILLER);
  always @* begin
    bit_valid = 1'b0;
    bit_val   = sym;
    viol      = 1'b0;
    if (sym_valid) begin
      if (!rx_two) begin
        bit_valid = 1'b1;
        if (coder_enable && line_code_select == `RSC_CODE_NRZM)
          bit_val = sym ^ s1;
        else if (coder_enable && line_code_select == `RSC_CODE_NRZS)
          bit_val = ~(sym ^ s1);
      end else if (rx_havea) begin
        bit_val = (line_code_select == `RSC_CODE_MANL) ? s1 : (s1 ^ sym);
        case (line_code_select)
          `RSC_CODE_MANL: viol = (s1 == sym);
          `RSC_CODE_MANM: viol = (s1 == s2);
          default:        viol = (s1 == sym) & ~rx_prevbit & (s1 == s2);
        endcase
        bit_valid = ~viol;
      end
    end
  end
  wire [7:0] rx_next_sh = {rx_sh[6:0], bit_val};
  wire start_viol = viol & (start_detect_mode == `RSC_START_VIOL);
  wire start_pat  = bit_valid & (start_detect_mode == `RSC_START_PATTERN) &
                    (rx_next_sh == start_pattern_value);
  wire start_pin  = receiver_enable & (start_detect_mode == `RSC_START_PIN) &
                    radio_pattern_pin & ~pat_prev;
  wire start_det  = start_viol | start_pat | start_pin;
  wire byte_done  = bit_valid & ~start_det & (rx_bits == 3'h7);
  wire rx_push    = byte_done & ~rx_full;
  wire [AW:0] rx_cnt_after = rx_cnt + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      receiver_enable             <= 1'b0;
      transmitter_enable          <= 1'b0;
      rx_external_bitclock_select <= 1'b0;
      tx_external_bitclock_select <= 1'b0;
      coder_enable                <= 1'b0;
      line_code_select            <= `RSC_CODE_NRZL;
      baud_fine_factor            <= 4'h0;
      baud_coarse_factor          <= 2'h0;
      start_detect_mode           <= `RSC_START_OFF;
      rx_interrupt_source         <= 3'h0;
      start_pattern_value         <= 8'h00;
      external_clock_select       <= 1'b0;
      rx_overrun_flag             <= 1'b0;
      prdata      <= 32'h0000_0000;
      tx_rd       <= {AW{1'b0}};
      tx_wr       <= {AW{1'b0}};
      tx_cnt      <= {(AW+1){1'b0}};
      rx_rd       <= {AW{1'b0}};
      rx_wr       <= {AW{1'b0}};
      rx_cnt      <= {(AW+1){1'b0}};
      ext_prev    <= 1'b0;
      ext_half    <= 1'b0;
      pre_cnt     <= 11'h000;
      os_cnt      <= 4'h0;
      bclk_prev   <= 1'b0;
      tx_busy     <= 1'b0;
      tx_sh       <= 8'h00;
      tx_bit      <= 3'h0;
      tx_half     <= 1'b0;
      tx_code_on  <= 1'b0;
      tx_code     <= `RSC_CODE_NRZL;
      tx_prevb    <= 1'b0;
      radio_tx_data_pin <= 1'b0;
      tx_irq      <= 1'b0;
      rx_irq      <= 1'b0;
      rx_phase    <= 4'h0;
      rx_lvl      <= 1'b0;
      s1          <= 1'b0;
      s2          <= 1'b0;
      rx_havea    <= 1'b0;
      rx_prevbit  <= 1'b0;
      rx_sh       <= 8'h00;
      rx_bits     <= 3'h0;
      pat_prev    <= 1'b0;
    end else begin
      // register writes and reads
      if (wr_en & a_ctrl) begin
        receiver_enable             <= pwdata[`RSC_CTRL_RXEN];
        transmitter_enable          <= pwdata[`RSC_CTRL_TXEN];
        rx_external_bitclock_select <= pwdata[`RSC_CTRL_RXEXT];
        tx_external_bitclock_select <= pwdata[`RSC_CTRL_TXEXT];
        coder_enable                <= pwdata[`RSC_CTRL_CODEN];
        line_code_select            <= pwdata[`RSC_CTRL_CODE_HI:`RSC_CTRL_CODE_LO];
      end
      if (wr_en & a_baud) begin
        baud_fine_factor    <= pwdata[`RSC_BAUD_FINE_HI:`RSC_BAUD_FINE_LO];
        baud_coarse_factor  <= pwdata[`RSC_BAUD_CRS_HI:`RSC_BAUD_CRS_LO];
        start_detect_mode   <= pwdata[`RSC_BAUD_START_HI:`RSC_BAUD_START_LO];
        rx_interrupt_source <= pwdata[`RSC_BAUD_IRQ_HI:`RSC_BAUD_IRQ_LO];
      end
      if (wr_en & a_pat)
        start_pattern_value <= pwdata[7:0];
      if (wr_en & a_sys)
        external_clock_select <= pwdata[0];
      // overrun: a new drop beats a software clear
      if (byte_done & rx_full)
        rx_overrun_flag <= 1'b1;
      else if (wr_en & a_st & pwdata[`RSC_ST_OVERRUN])
        rx_overrun_flag <= 1'b0;
      if (setup) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `RSC_ADDR_CTRL:    prdata[7:0] <= {line_code_select, coder_enable,
                               tx_external_bitclock_select, rx_external_bitclock_select,
                               transmitter_enable, receiver_enable};
          `RSC_ADDR_BAUD:    prdata[10:0] <= {rx_interrupt_source, start_detect_mode,
                               baud_coarse_factor, baud_fine_factor};
          `RSC_ADDR_PATTERN: prdata[7:0] <= start_pattern_value;
          `RSC_ADDR_RXDATA:  prdata[7:0] <= rx_empty ? 8'h00 : rx_mem[rx_rd];
          `RSC_ADDR_STATUS:  prdata[4:0] <= {rx_overrun_flag, rx_full, rx_empty,
                               tx_full, tx_empty};
          `RSC_ADDR_SYSCLK:  prdata[0] <= external_clock_select;
          default:           prdata <= 32'h0000_0000;
        endcase
      end
      // system clock halving
      ext_prev <= ext_clk_in;
      if (ext_rise)
        ext_half <= ~ext_half;
      // baud generator
      if (core_en) begin
        if (pre_cnt >= div_m1)
          pre_cnt <= 11'h000;
        else
          pre_cnt <= pre_cnt + 11'h001;
      end
      if (os_tick)
        os_cnt <= os_cnt + 4'h1;
      bclk_prev <= radio_bitclock_pin;
      // transmit fifo
      if (tx_push) begin
        tx_mem[tx_wr] <= pwdata[7:0];
        tx_wr <= tx_wr + 1'b1;
      end
      if (tx_pop)
        tx_rd <= tx_rd + 1'b1;
      tx_cnt <= tx_cnt + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
      tx_irq <= tx_pop & (tx_cnt == 1) & ~tx_push;
      // transmit shifter
      if (tx_load_idle) begin
        tx_busy    <= 1'b1;
        tx_code_on <= coder_enable;
        tx_code    <= line_code_select;
        radio_tx_data_pin <= next_line;
        if (coder_enable & (line_code_select == `RSC_CODE_MANL |
            line_code_select == `RSC_CODE_MANM | line_code_select == `RSC_CODE_MILLER)) begin
          tx_sh   <= tx_head;
          tx_bit  <= 3'h0;
          tx_half <= 1'b1;
        end else begin
          tx_prevb <= tx_head[7];
          tx_sh    <= {tx_head[6:0], 1'b0};
          tx_bit   <= 3'h1;
          tx_half  <= 1'b0;
        end
      end else if (tx_tick & tx_busy) begin
        radio_tx_data_pin <= next_line;
        if (tx_two & ~tx_half) begin
          tx_half <= 1'b1;
        end else begin
          tx_half  <= 1'b0;
          tx_prevb <= tx_sh[7];
          tx_sh    <= {tx_sh[6:0], 1'b0};
          tx_bit   <= tx_bit + 3'h1;
        end
      end
      if (tx_load_next) begin
        tx_sh      <= tx_head;
        tx_code_on <= coder_enable;
        tx_code    <= line_code_select;
      end else if (tx_bit_end & (tx_bit == 3'h7)) begin
        tx_busy <= 1'b0;
      end
      // receive symbol phase follows line edges
      rx_lvl <= radio_rx_data_pin;
      if (radio_rx_data_pin != rx_lvl)
        rx_phase <= 4'h0;
      else if (os_tick)
        rx_phase <= rx_phase + 4'h1;
      pat_prev <= radio_pattern_pin;
      // receive decoder state
      if (sym_valid) begin
        s1 <= sym;
        s2 <= s1;
        if (rx_two)
          rx_havea <= viol | ~rx_havea;
        else
          rx_havea <= 1'b0;
      end
      if (bit_valid) begin
        rx_prevbit <= bit_val;
        rx_sh      <= rx_next_sh;
        rx_bits    <= rx_bits + 3'h1;
      end
      // receive fifo
      if (start_det) begin
        rx_rd   <= {AW{1'b0}};
        rx_wr   <= {AW{1'b0}};
        rx_cnt  <= {(AW+1){1'b0}};
        rx_bits <= 3'h0;
      end else begin
        if (rx_push) begin
          rx_mem[rx_wr] <= rx_next_sh;
          rx_wr <= rx_wr + 1'b1;
        end
        if (rx_pop)
          rx_rd <= rx_rd + 1'b1;
        rx_cnt <= rx_cnt_after;
      end
      case (rx_interrupt_source)
        `RSC_IRQ_START: rx_irq <= start_det;
        `RSC_IRQ_BYTE:  rx_irq <= rx_push & ~start_det;
        `RSC_IRQ_FULL:  rx_irq <= rx_push & ~start_det & (rx_cnt_after == DEPTH);
        default:        rx_irq <= 1'b0;
      endcase
    end
  end
endmodule

`default_nettype wire

// File: tb/rsc_radio_serial_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.vh"
module rsc_radio_serial_asserts (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // radio and interrupts
  input wire        radio_tx_data_pin,
  input wire        tx_irq,
  input wire        rx_irq
);
  reg  [7:0] ctrl;
  reg  [2:0] src;
  reg  [7:0] gap;
  reg        last_pin;
  wire       wr  = psel && penable && pwrite && pready;
  wire       bad = paddr > `RSC_ADDR_SYSCLK || paddr[1:0] != 2'h0;
  // shadows of control fields, taken at the same edge as the write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= 8'h00;
      src <= 3'h0;
      gap <= 8'hff;
      last_pin <= 1'b0;
    end else begin
      if (wr && paddr == `RSC_ADDR_CTRL) ctrl <= pwdata[7:0];
      if (wr && paddr == `RSC_ADDR_BAUD) src <= pwdata[10:8];
      last_pin <= radio_tx_data_pin;
      if (radio_tx_data_pin != last_pin) gap <= 8'h00;
      else if (gap != 8'hff) gap <= gap + 8'h01;
    end
  end
  reset_quiet_a: assert property (@(posedge clk) rst |-> !tx_irq && !rx_irq && !radio_tx_data_pin)
    else $error("outputs active in reset");
  tx_irq_pulse_a: assert property (@(posedge clk) disable iff (rst) tx_irq |=> !tx_irq)
    else $error("tx irq longer than one cycle");
  rx_irq_pulse_a: assert property (@(posedge clk) disable iff (rst) rx_irq |=> !rx_irq)
    else $error("rx irq longer than one cycle");
  rx_irq_src_a: assert property (@(posedge clk) disable iff (rst)
    rx_irq |-> src == 3'h1 || src == 3'h2 || src == 3'h4)
    else $error("rx irq with no source selected");
  tx_frozen_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl[1] && !$past(ctrl[1]) |-> $stable(radio_tx_data_pin) && !tx_irq)
    else $error("transmitter active while disabled");
  symbol_gap_a: assert property (@(posedge clk) disable iff (rst)
    $changed(radio_tx_data_pin) && !ctrl[3] |-> gap >= 8'd15)
    else $error("symbol shorter than sixteen cycles");
  unmapped_err_a: assert property (@(posedge clk) disable iff (rst)
    psel && penable && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (@(posedge clk) disable iff (rst)
    psel && penable && !bad |-> !pslverr && pready)
    else $error("mapped access refused");
  rx_byte_wide_a: assert property (@(posedge clk) disable iff (rst)
    psel && penable && !pwrite && paddr == `RSC_ADDR_RXDATA |-> prdata[31:8] == 24'h0)
    else $error("rx data upper bits set");
endmodule
bind rsc_radio_serial rsc_radio_serial_asserts rsc_radio_serial_asserts_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .radio_tx_data_pin(radio_tx_data_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// File: tb/rsc_radio_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_radio_model (
  // clock
  input  wire logic clk,
  // radio pins
  output var logic  rx_line,
  output var logic  bit_clk,
  output var logic  pat_pin,
  input  wire logic tx_line
);
  logic [15:0] got;
  initial begin
    rx_line = 1'b0;
    bit_clk = 1'b0;
    pat_pin = 1'b0;
    got = 16'h0;
  end
  // data settles four cycles before the rising bit clock, msb first
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rx_line <= b[i];
      repeat (4) @(posedge clk);
      bit_clk <= 1'b1;
      repeat (4) @(posedge clk);
      bit_clk <= 1'b0;
    end
  endtask
  // clock runs only while symbols are wanted; sample well after the rise
  task automatic clock_tx(input int n);
    for (int i = 0; i < n; i++) begin
      bit_clk <= 1'b1;
      repeat (6) @(posedge clk);
      got = {got[14:0], tx_line};
      bit_clk <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic pulse_pat();
    pat_pin <= ~pat_pin;
    repeat (4) @(posedge clk);
    pat_pin <= ~pat_pin;
  endtask
endmodule
`default_nettype wire

// File: tb/rsc_radio_serial_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defines.vh"
module rsc_radio_serial_tb;
  logic        clk, rst, psel, penable, pwrite, err, lv, ext_clk;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, rd;
  logic [7:0]  b, q[$];
  logic [2:0]  cd;
  wire         pready, pslverr, tx_pin, tx_irq, rx_irq, rx_line, bit_clk, pat_pin;
  wire  [31:0] prdata;
  integer      failures, tests_run, seed, tx_n, rx_n, n, m, k, per;
  rsc_radio_serial #(.DEPTH(4)) rsc_radio_serial_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .radio_rx_data_pin(rx_line),
    .radio_bitclock_pin(bit_clk), .radio_pattern_pin(pat_pin), .radio_tx_data_pin(tx_pin),
    .ext_clk_in(ext_clk), .tx_irq(tx_irq), .rx_irq(rx_irq));
  rsc_radio_model rsc_radio_model_i (.clk(clk), .rx_line(rx_line), .bit_clk(bit_clk),
    .pat_pin(pat_pin), .tx_line(tx_pin));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (tx_irq === 1'b1) tx_n <= tx_n + 1;
    if (rx_irq === 1'b1) rx_n <= rx_n + 1;
    ext_clk <= ~ext_clk;
  end
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic [7:0] nrz(input logic [2:0] c, input logic [7:0] d, input logic l);
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) begin
      if (c == `RSC_CODE_NRZL) l = d[i];
      else if (d[i] == (c == `RSC_CODE_NRZM)) l = ~l;
      r[i] = l;
    end
    return r;
  endfunction
  task automatic wait_edge(output int c);
    logic l0;
    l0 = tx_pin;
    c = 0;
    while (tx_pin === l0 && c < 3000) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, failures, tests_run, tx_n, rx_n, ext_clk} = '0;
    seed = 48053;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(0, `RSC_ADDR_STATUS, 0);
    chk(rd, 32'h5, "status after reset");
    apb(0, `RSC_ADDR_CTRL, 0);
    chk(rd, 32'h0, "ctrl after reset");
    for (k = 0; k < 3; k++) begin
      a = 12'h800 | ($random(seed) & 12'h7fc);
      apb(1, a, $random(seed));
      chk(err, 1'b1, "unmapped write");
      apb(0, a, 0);
      chk(err, 1'b1, "unmapped read refused");
      chk(rd, 32'h0, "unmapped read");
    end
    // fine 0010 coarse 01 gives 12, then random fine, then the halved external clock
    for (k = 0; k < 3; k++) begin
      b = (k == 1) ? ($random(seed) & 8'h0f) : (k ? 8'h00 : 8'h12);
      // external input toggles every cycle, so the core runs at a quarter rate
      per = 16 * (b[3:0] + 1) * (b[4] ? 4 : 1) * ((k == 2) ? 4 : 1);
      if (k == 2) apb(1, `RSC_ADDR_SYSCLK, 1);
      apb(1, `RSC_ADDR_BAUD, b);
      apb(1, `RSC_ADDR_CTRL, 8'h52);
      apb(1, `RSC_ADDR_TXDATA, 0);
      wait_edge(n);
      wait_edge(n);
      chk(n, per, "symbol period");
      repeat (8 * per) @(posedge clk);
      apb(1, `RSC_ADDR_CTRL, 0);
    end
    apb(1, `RSC_ADDR_SYSCLK, 0);
    // every line code, clocked by the radio
    apb(1, `RSC_ADDR_BAUD, 0);
    q.delete();
    for (k = 0; k < 6; k++) begin
      cd = (k == 5) ? `RSC_CODE_MILLER : k;
      b = $random(seed);
      lv = tx_pin;
      apb(1, `RSC_ADDR_CTRL, {cd, 5'h1a});
      apb(1, `RSC_ADDR_TXDATA, b);
      m = (k >= 3) ? 16 : 8;
      rsc_radio_model_i.clock_tx(m);
      if (m == 8)
        chk(rsc_radio_model_i.got[7:0], nrz(cd, b, lv), "nrz symbols");
      else
        for (n = 0; n < 8; n++)
          chk(rsc_radio_model_i.got[2*n+1] ^ rsc_radio_model_i.got[2*n],
              (k == 3) ? 1'b1 : b[n], "half symbol pair");
    end
    // raw byte, coder switched on mid byte, then coded zeros
    n = tx_n;
    b = $random(seed);
    apb(1, `RSC_ADDR_CTRL, 8'h4a);
    apb(1, `RSC_ADDR_TXDATA, b);
    rsc_radio_model_i.clock_tx(1);
    apb(1, `RSC_ADDR_CTRL, 8'h5a);
    apb(1, `RSC_ADDR_TXDATA, 0);
    rsc_radio_model_i.clock_tx(15);
    chk(rsc_radio_model_i.got, {b, nrz(`RSC_CODE_NRZS, 8'h00, b[0])}, "raw then coded");
    chk(tx_n - n, 2, "tx irq per emptying load");
    // fill the frozen fifo, fifth byte refused
    apb(1, `RSC_ADDR_CTRL, 8'h48);
    for (k = 0; k < 5; k++) begin
      q.push_back($random(seed));
      apb(1, `RSC_ADDR_TXDATA, q[k]);
    end
    apb(0, `RSC_ADDR_STATUS, 0);
    chk(rd[1:0], 2'b10, "tx fifo full");
    n = tx_n;
    apb(1, `RSC_ADDR_CTRL, 8'h4a);
    rsc_radio_model_i.clock_tx(32);
    chk(rsc_radio_model_i.got, {q[2], q[3]}, "tx fifo order");
    chk(tx_n - n, 1, "tx irq once on empty");
    apb(1, `RSC_ADDR_CTRL, 8'h48);
    // receive: pattern start, full irq, overrun
    q.delete();
    apb(1, `RSC_ADDR_CTRL, 8'h15);
    apb(1, `RSC_ADDR_PATTERN, 8'hff);
    apb(1, `RSC_ADDR_BAUD, 32'h1c0);
    n = rx_n;
    rsc_radio_model_i.send_byte(8'hff);
    repeat (4) @(posedge clk);
    chk(rx_n - n, 1, "start irq");
    apb(1, `RSC_ADDR_BAUD, 32'h4c0);
    n = rx_n;
    // bits 7 and 3 low: no eight ones in a row, even right after the pattern
    for (k = 0; k < 5; k++) begin
      q.push_back($random(seed) & 8'h77);
      rsc_radio_model_i.send_byte(q[k]);
    end
    repeat (4) @(posedge clk);
    chk(rx_n - n, 1, "full irq");
    apb(0, `RSC_ADDR_STATUS, 0);
    chk(rd[4:2], 3'b110, "overrun and full");
    for (k = 0; k < 5; k++) begin
      apb(0, `RSC_ADDR_RXDATA, 0);
      chk(rd, (k < 4) ? q[k] : 8'h00, "rx data");
    end
    apb(1, `RSC_ADDR_STATUS, 32'h10);
    apb(0, `RSC_ADDR_STATUS, 0);
    chk(rd[4:2], 3'b001, "overrun cleared");
    for (k = 0; k < 2; k++) rsc_radio_model_i.send_byte($random(seed) & 8'hf7);
    rsc_radio_model_i.send_byte(8'hff);
    apb(0, `RSC_ADDR_STATUS, 0);
    chk(rd[2], 1'b1, "flush on pattern");
    apb(1, `RSC_ADDR_BAUD, 32'h180);
    rsc_radio_model_i.send_byte($random(seed) & 8'hf7);
    n = rx_n;
    rsc_radio_model_i.pulse_pat();
    repeat (4) @(posedge clk);
    chk(rx_n - n, 1, "pin start irq");
    apb(0, `RSC_ADDR_STATUS, 0);
    chk(rd[2], 1'b1, "flush on pin");
    apb(1, `RSC_ADDR_CTRL, 0);
    rsc_radio_model_i.send_byte($random(seed));
    apb(0, `RSC_ADDR_STATUS, 0);
    chk(rd[2], 1'b1, "receiver off");
    // manchester level: one pair of equal halves is a violation start
    apb(1, `RSC_ADDR_CTRL, 8'h75);
    apb(1, `RSC_ADDR_BAUD, 32'h140);
    n = rx_n;
    rsc_radio_model_i.send_byte(8'hcc);
    repeat (4) @(posedge clk);
    chk(rx_n - n, 1, "violation start irq");
    tally_and_finish();
  end
endmodule
`default_nettype wire
